// >>> hdl/fcu_pkg.sv
// Constants, codes and helper functions shared by the flash command unit
// Summary of operation
// - Mode codes 0..5: standby, read, program, erase, hidden
// - Extended modes: CRC read, auto-increment read/program
// - CRC read runs from address to boundary end
// - Fire only on 0x46 then 0xB9 with enable
// - Enable bit clear blocks every operation
// - Bit 6 selects boot source after reset
// - Bit 5 one pulses system reset, self-clears
// - Bit 4 reports last command failure
// - Data area spans boundary*256 to boot start-1
// - Hidden read returns boundary in data port
// - Hidden write loads boundary from data port
// - Processor stalled until operation completes
// - Byte read leaves flash byte in data port
// - Program writes data port byte to address
// - Page erase clears one 512-byte page
// - Erase ignores low address; hidden ignores high
// - Low address indexes the hidden register
// - Program outside data area is ignored, except below it when boot-area code runs
package fcu_pkg;
   localparam logic [7:0] OFF_DATA_PORT = 8'hE2;
   localparam logic [7:0] OFF_ADDR_HIGH = 8'hE3;
   localparam logic [7:0] OFF_ADDR_LOW = 8'hE4;
   localparam logic [7:0] OFF_MODE_SELECT = 8'hE5;
   localparam logic [7:0] OFF_CMD_PORT = 8'hE6;
   localparam logic [7:0] OFF_PROG_CONTROL = 8'hE7;
   localparam logic [7:0] HID_IDX_LOW_BOUND = 8'h03;

   localparam logic [7:0] RST_DATA_PORT = 8'hFF;
   localparam logic [7:0] RST_ADDR = 8'h00;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_LOW_BOUND = 8'h70;

   localparam int BIT_PROG_ENABLE = 7;
   localparam int BIT_BOOT_SOURCE = 6;
   localparam int BIT_SOFT_RESET = 5;
   localparam int BIT_CMD_FAIL = 4;

   localparam logic [7:0] UNLOCK_FIRST = 8'h46;
   localparam logic [7:0] UNLOCK_SECOND = 8'hB9;

   localparam logic [7:0] MODE_STANDBY = 8'h00;
   localparam logic [7:0] MODE_READ = 8'h01;
   localparam logic [7:0] MODE_PROGRAM = 8'h02;
   localparam logic [7:0] MODE_ERASE = 8'h03;
   localparam logic [7:0] MODE_HID_WRITE = 8'h04;
   localparam logic [7:0] MODE_HID_READ = 8'h05;
   localparam logic [7:0] MODE_CRC_READ = 8'h80;
   localparam logic [7:0] MODE_READ_INC = 8'h81;
   localparam logic [7:0] MODE_PROG_INC = 8'h82;

   localparam logic [15:0] PAGE_LAST_OFFSET = 16'h01FF;

   typedef enum logic [1:0] {FCU_OP_READ, FCU_OP_PROGRAM, FCU_OP_ERASE} fcu_op_t;

   function automatic logic is_read_mode(input logic [7:0] m);
      return (m == MODE_READ) || (m == MODE_READ_INC) || (m == MODE_CRC_READ);
   endfunction

   function automatic logic is_prog_mode(input logic [7:0] m);
      return (m == MODE_PROGRAM) || (m == MODE_PROG_INC);
   endfunction

   function automatic logic [15:0] page_base(input logic [7:0] hi);
      return {hi[7:1], 9'h000};
   endfunction
endpackage

// >>> hdl/fcu_unlock.sv
// Two-byte unlock sequence detector on the command port
`timescale 1ns/10ps
module fcu_unlock (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic cmd_wr_in,
   input wire logic [7:0] cmd_data_in,
   output logic fire_out
);
   import fcu_pkg::*;

   logic armed;

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         armed <= 1'b0;
      end else if (cmd_wr_in) begin
         // Any byte other than the first unlock byte drops the partial sequence
         armed <= (cmd_data_in == UNLOCK_FIRST);
      end
   end

   assign fire_out = cmd_wr_in && armed && (cmd_data_in == UNLOCK_SECOND);

   property p_wrong_byte_disarms;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      (cmd_wr_in && cmd_data_in != UNLOCK_FIRST) ##1 (cmd_wr_in && cmd_data_in == UNLOCK_SECOND)
         |-> !fire_out;
   endproperty
   a_wrong_byte_disarms: assert property (p_wrong_byte_disarms)
      else $error("Unlock fired without a preceding first byte");

   // Same hazard with an idle cycle between the writes, as software usually issues them
   property p_wrong_byte_gap;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      (cmd_wr_in && cmd_data_in != UNLOCK_FIRST) ##1 !cmd_wr_in ##1
         (cmd_wr_in && cmd_data_in == UNLOCK_SECOND) |-> !fire_out;
   endproperty
   a_wrong_byte_gap: assert property (p_wrong_byte_gap)
      else $error("Unlock fired after a wrong command byte");
endmodule

// >>> hdl/fcu_area_check.sv
// Data-area window check for program and erase destinations
`timescale 1ns/10ps
module fcu_area_check (
   input wire logic [15:0] dest_addr_in,
   input wire logic [7:0] low_bound_in,
   input wire logic [15:0] boot_start_in,
   input wire logic boot_exec_in,
   output logic allowed_out
);
   logic [15:0] area_low;

   assign area_low = {low_bound_in, 8'h00};

   // Boot-area code may reach the whole of memory below the boot area;
   // application code only the data area
   always_comb begin
      if (boot_exec_in) begin
         allowed_out = (dest_addr_in < boot_start_in);
      end else begin
         allowed_out = (dest_addr_in >= area_low) && (dest_addr_in < boot_start_in);
      end
   end
endmodule

// >>> hdl/fcu_top.sv
// Flash command unit: registers, unlock trigger, flash sequencing and stall
`timescale 1ns/10ps
module fcu_top (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [7:0] sfr_wdata_in,
   output logic [7:0] sfr_rdata_out,
   input wire logic [15:0] boot_start_in,
   input wire logic boot_exec_in,
   output logic cpu_stall_out,
   output logic soft_reset_out,
   output logic boot_source_out,
   output logic flash_req_out,
   output fcu_pkg::fcu_op_t flash_op_out,
   output logic [15:0] flash_addr_out,
   output logic [7:0] flash_wdata_out,
   input wire logic flash_ack_in,
   input wire logic flash_fail_in,
   input wire logic [7:0] flash_rdata_in,
   output logic [7:0] crc_data_out,
   output logic crc_valid_out
);
   import fcu_pkg::*;

   typedef enum logic [1:0] {FCU_IDLE, FCU_FLASH, FCU_END} fcu_state_t;

   fcu_state_t state;
   fcu_state_t next_state;
   logic [7:0] flash_data_port;
   logic [7:0] flash_addr_high;
   logic [7:0] flash_addr_low;
   logic [7:0] flash_mode_select;
   logic [7:0] data_area_low_bound;
   logic prog_enable;
   logic boot_source_select;
   logic command_fail_flag;
   logic crc_more;
   logic unlock_fire;
   logic fire;
   logic accepted;
   logic area_ok;
   logic [15:0] cur_addr;
   logic [15:0] check_addr;
   logic [15:0] crc_end;
   logic flash_done;
   logic hid_hit;
   logic wr_data;
   logic wr_ahi;
   logic wr_alo;
   logic wr_mode;
   logic wr_ctrl;

   assign wr_data = sfr_wr_in && (sfr_addr_in == OFF_DATA_PORT);
   assign wr_ahi = sfr_wr_in && (sfr_addr_in == OFF_ADDR_HIGH);
   assign wr_alo = sfr_wr_in && (sfr_addr_in == OFF_ADDR_LOW);
   assign wr_mode = sfr_wr_in && (sfr_addr_in == OFF_MODE_SELECT);
   assign wr_ctrl = sfr_wr_in && (sfr_addr_in == OFF_PROG_CONTROL);

   fcu_unlock u_unlock (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .cmd_wr_in(sfr_wr_in && (sfr_addr_in == OFF_CMD_PORT)),
      .cmd_data_in(sfr_wdata_in),
      .fire_out(unlock_fire)
   );

   assign cur_addr = {flash_addr_high, flash_addr_low};
   // Erase checks the page base so the low byte cannot sway the decision
   assign check_addr = (flash_mode_select == MODE_ERASE) ?
                       page_base(flash_addr_high) : cur_addr;

   fcu_area_check u_area (
      .dest_addr_in(check_addr),
      .low_bound_in(data_area_low_bound),
      .boot_start_in(boot_start_in),
      .boot_exec_in(boot_exec_in),
      .allowed_out(area_ok)
   );

   assign crc_end = {data_area_low_bound, 8'h00} + PAGE_LAST_OFFSET;
   assign fire = unlock_fire && prog_enable && (state == FCU_IDLE);
   assign flash_done = (state == FCU_FLASH) && flash_ack_in;
   assign hid_hit = (flash_addr_low == HID_IDX_LOW_BOUND);

   // Mode decode decides whether the trigger starts anything
   always_comb begin
      case (flash_mode_select)
         MODE_READ, MODE_READ_INC, MODE_CRC_READ: accepted = 1'b1;
         MODE_PROGRAM, MODE_PROG_INC, MODE_ERASE: accepted = area_ok;
         MODE_HID_WRITE, MODE_HID_READ: accepted = 1'b1;
         default: accepted = 1'b0;
      endcase
   end

   always_comb begin
      next_state = state;
      case (state)
         FCU_IDLE: begin
            if (fire && accepted) begin
               if ((flash_mode_select == MODE_HID_WRITE) ||
                   (flash_mode_select == MODE_HID_READ)) begin
                  next_state = FCU_END;
               end else begin
                  next_state = FCU_FLASH;
               end
            end
         end
         FCU_FLASH: begin
            if (flash_ack_in) begin
               next_state = FCU_END;
            end
         end
         FCU_END: begin
            next_state = crc_more ? FCU_FLASH : FCU_IDLE;
         end
         default: next_state = FCU_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         state <= FCU_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Stall covers the whole operation, including the gap between CRC reads
   assign cpu_stall_out = (state != FCU_IDLE);
   assign flash_req_out = (state == FCU_FLASH);

   always_comb begin
      if (is_prog_mode(flash_mode_select)) begin
         flash_op_out = FCU_OP_PROGRAM;
      end else if (flash_mode_select == MODE_ERASE) begin
         flash_op_out = FCU_OP_ERASE;
      end else begin
         flash_op_out = FCU_OP_READ;
      end
   end

   assign flash_addr_out = (flash_mode_select == MODE_ERASE) ?
                           page_base(flash_addr_high) : cur_addr;
   assign flash_wdata_out = flash_data_port;

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         crc_more <= 1'b0;
      end else if (flash_done) begin
         // A failed read stops the CRC walk early
         crc_more <= (flash_mode_select == MODE_CRC_READ) && !flash_fail_in &&
                     (cur_addr != crc_end);
      end else if (state == FCU_END) begin
         crc_more <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         flash_data_port <= RST_DATA_PORT;
      end else if (flash_done && (flash_mode_select == MODE_READ ||
                                  flash_mode_select == MODE_READ_INC)) begin
         flash_data_port <= flash_rdata_in;
      end else if (fire && flash_mode_select == MODE_HID_READ) begin
         flash_data_port <= hid_hit ? data_area_low_bound : 8'h00;
      end else if (wr_data) begin
         flash_data_port <= sfr_wdata_in;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         flash_addr_high <= RST_ADDR;
         flash_addr_low <= RST_ADDR;
      end else if (flash_done && (flash_mode_select == MODE_READ_INC ||
                                  flash_mode_select == MODE_PROG_INC ||
                                  crc_end != cur_addr && flash_mode_select == MODE_CRC_READ)) begin
         {flash_addr_high, flash_addr_low} <= cur_addr + 16'h0001;
      end else begin
         if (wr_ahi) begin
            flash_addr_high <= sfr_wdata_in;
         end
         if (wr_alo) begin
            flash_addr_low <= sfr_wdata_in;
         end
      end
   end

   // Reserved bits are stored as written; undefined codes simply never start
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         flash_mode_select <= RST_MODE;
      end else if (wr_mode) begin
         flash_mode_select <= sfr_wdata_in;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         data_area_low_bound <= RST_LOW_BOUND;
      end else if (fire && flash_mode_select == MODE_HID_WRITE && hid_hit) begin
         data_area_low_bound <= flash_data_port;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         prog_enable <= 1'b0;
         boot_source_select <= 1'b0;
      end else if (wr_ctrl) begin
         prog_enable <= sfr_wdata_in[BIT_PROG_ENABLE];
         boot_source_select <= sfr_wdata_in[BIT_BOOT_SOURCE];
      end
   end
   assign boot_source_out = boot_source_select;

   // Flash result wins over a software write in the same cycle
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         command_fail_flag <= 1'b0;
      end else if (flash_done) begin
         command_fail_flag <= flash_fail_in;
      end else if (wr_ctrl) begin
         command_fail_flag <= sfr_wdata_in[BIT_CMD_FAIL];
      end
   end

   // The trigger bit is never stored, so it always reads back as zero
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         soft_reset_out <= 1'b0;
      end else begin
         soft_reset_out <= wr_ctrl && sfr_wdata_in[BIT_SOFT_RESET];
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         crc_data_out <= 8'h00;
         crc_valid_out <= 1'b0;
      end else begin
         crc_valid_out <= flash_done && (flash_mode_select == MODE_CRC_READ);
         if (flash_done && flash_mode_select == MODE_CRC_READ) begin
            crc_data_out <= flash_rdata_in;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         sfr_rdata_out <= 8'h00;
      end else if (sfr_rd_in) begin
         case (sfr_addr_in)
            OFF_DATA_PORT: sfr_rdata_out <= flash_data_port;
            OFF_ADDR_HIGH: sfr_rdata_out <= flash_addr_high;
            OFF_ADDR_LOW: sfr_rdata_out <= flash_addr_low;
            OFF_MODE_SELECT: sfr_rdata_out <= flash_mode_select;
            OFF_PROG_CONTROL: sfr_rdata_out <= {prog_enable, boot_source_select, 1'b0,
                                                command_fail_flag, 4'h0};
            default: sfr_rdata_out <= 8'h00;
         endcase
      end
   end

   property p_disabled_blocks;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      (unlock_fire && !prog_enable && state == FCU_IDLE) |=> !cpu_stall_out;
   endproperty
   a_disabled_blocks: assert property (p_disabled_blocks)
      else $error("Operation started with enable bit clear");

   property p_fire_stalls;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      (fire && accepted) |=> cpu_stall_out;
   endproperty
   a_fire_stalls: assert property (p_fire_stalls)
      else $error("Accepted trigger did not stall the processor");

   property p_read_lands;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      (flash_done && flash_mode_select == MODE_READ) |=>
         (flash_data_port == $past(flash_rdata_in)) ##1 !cpu_stall_out;
   endproperty
   a_read_lands: assert property (p_read_lands)
      else $error("Read byte missing from data port or stall too long");

   // A second trigger write on the next cycle legally stretches the pulse
   property p_soft_reset;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      (wr_ctrl && sfr_wdata_in[BIT_SOFT_RESET]) ##1
         !(wr_ctrl && sfr_wdata_in[BIT_SOFT_RESET]) |-> soft_reset_out ##1 !soft_reset_out;
   endproperty
   a_soft_reset: assert property (p_soft_reset)
      else $error("Soft reset pulse wrong");

   property p_boot_select;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      wr_ctrl |=> boot_source_out == $past(sfr_wdata_in[BIT_BOOT_SOURCE]);
   endproperty
   a_boot_select: assert property (p_boot_select)
      else $error("Boot source not taken from control write");

   property p_fail_flag;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      flash_done |=> command_fail_flag == $past(flash_fail_in);
   endproperty
   a_fail_flag: assert property (p_fail_flag)
      else $error("Fail flag does not follow last result");

   property p_erase_page;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      (flash_req_out && flash_op_out == FCU_OP_ERASE) |-> flash_addr_out[8:0] == 9'h000;
   endproperty
   a_erase_page: assert property (p_erase_page)
      else $error("Erase address not page aligned");

   property p_outside_ignored;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      (fire && is_prog_mode(flash_mode_select) && !area_ok) |=> !cpu_stall_out [*2];
   endproperty
   a_outside_ignored: assert property (p_outside_ignored)
      else $error("Program outside data area was not ignored");

   property p_hid_write;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      (fire && flash_mode_select == MODE_HID_WRITE && hid_hit) |=>
         data_area_low_bound == $past(flash_data_port) ##1 !cpu_stall_out;
   endproperty
   a_hid_write: assert property (p_hid_write)
      else $error("Boundary not updated by hidden write");

   property p_hid_read;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      (fire && flash_mode_select == MODE_HID_READ && hid_hit) |=>
         flash_data_port == data_area_low_bound;
   endproperty
   a_hid_read: assert property (p_hid_read)
      else $error("Boundary not returned by hidden read");

   c_read: cover property (@(posedge ref_clk_in) flash_done && flash_mode_select == MODE_READ);
   c_prog: cover property (@(posedge ref_clk_in) flash_req_out && flash_op_out == FCU_OP_PROGRAM);
   c_crc: cover property (@(posedge ref_clk_in) crc_valid_out ##[1:20] crc_valid_out);
   c_hid: cover property (@(posedge ref_clk_in) fire && flash_mode_select == MODE_HID_WRITE);
endmodule

// >>> test/fcu_flash_model.sv
// Behavioural flash array answering the command unit's access requests
`timescale 1ns/10ps
module fcu_flash_model (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic req_in,
   input wire fcu_pkg::fcu_op_t op_in,
   input wire logic [15:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic [3:0] delay_in,
   input wire logic fail_mode_in,
   output logic ack_out,
   output logic fail_out,
   output logic [7:0] rdata_out
);
   import fcu_pkg::*;

   logic [7:0] mem [0:65535];
   logic [3:0] wait_cnt;

   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'hFF;
      end
   end

   // Read data is only valid with the ack; otherwise it toggles so stale bytes never match
   always @(posedge ref_clk_in) begin
      if (!rst_n_in || ack_out) begin
         ack_out <= 1'b0;
         fail_out <= 1'b0;
         wait_cnt <= 4'h0;
         rdata_out <= (!rst_n_in) ? 8'h5A : ~rdata_out;
      end else if (req_in && wait_cnt >= delay_in) begin
         ack_out <= 1'b1;
         fail_out <= fail_mode_in;
         rdata_out <= mem[addr_in];
         if (!fail_mode_in && op_in == FCU_OP_PROGRAM) begin
            // Programming can only clear bits, as a real array does
            mem[addr_in] <= mem[addr_in] & wdata_in;
         end
         if (!fail_mode_in && op_in == FCU_OP_ERASE) begin
            for (int i = 0; i < 512; i++) begin
               mem[{addr_in[15:9], i[8:0]}] <= 8'hFF;
            end
         end
      end else begin
         ack_out <= 1'b0;
         fail_out <= 1'b0;
         rdata_out <= ~rdata_out;
         if (req_in) begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
endmodule

// >>> test/testbench.sv
// Self-checking bench for the flash command unit
`timescale 1ns/10ps
module testbench;
   import fcu_pkg::*;
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [7:0] sfr_addr_in = 8'h00;
   logic sfr_wr_in = 1'b0;
   logic sfr_rd_in = 1'b0;
   logic [7:0] sfr_wdata_in = 8'h00;
   logic [7:0] sfr_rdata_out;
   logic [15:0] boot_start_in = 16'h3000;
   logic boot_exec_in = 1'b0;
   logic cpu_stall_out, soft_reset_out, boot_source_out, flash_req_out;
   fcu_op_t flash_op_out;
   logic [15:0] flash_addr_out;
   logic [7:0] flash_wdata_out, flash_rdata_in, crc_data_out, crc_last;
   logic flash_ack_in, flash_fail_in, crc_valid_out;
   logic [3:0] delay = 4'h0;
   logic fail_mode = 1'b0;
   int n_errors = 0;
   int cmp_count = 0;
   int crc_n = 0;

   fcu_top fcu_top_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
      .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
      .boot_start_in(boot_start_in), .boot_exec_in(boot_exec_in),
      .cpu_stall_out(cpu_stall_out), .soft_reset_out(soft_reset_out),
      .boot_source_out(boot_source_out), .flash_req_out(flash_req_out),
      .flash_op_out(flash_op_out), .flash_addr_out(flash_addr_out),
      .flash_wdata_out(flash_wdata_out), .flash_ack_in(flash_ack_in),
      .flash_fail_in(flash_fail_in), .flash_rdata_in(flash_rdata_in),
      .crc_data_out(crc_data_out), .crc_valid_out(crc_valid_out));

   fcu_flash_model fcu_flash_model_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .req_in(flash_req_out), .op_in(flash_op_out), .addr_in(flash_addr_out),
      .wdata_in(flash_wdata_out), .delay_in(delay), .fail_mode_in(fail_mode),
      .ack_out(flash_ack_in), .fail_out(flash_fail_in), .rdata_out(flash_rdata_in));

   initial begin
      forever #5 ref_clk_in = ~ref_clk_in;
   end

   always @(posedge ref_clk_in) begin
      if (crc_valid_out === 1'b1) begin
         crc_n <= crc_n + 1;
         crc_last <= crc_data_out;
      end
   end

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk_in);
      sfr_addr_in = a;
      sfr_wdata_in = d;
      sfr_wr_in = 1'b1;
      @(negedge ref_clk_in);
      sfr_wr_in = 1'b0;
   endtask

   task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge ref_clk_in);
      sfr_addr_in = a;
      sfr_rd_in = 1'b1;
      @(negedge ref_clk_in);
      sfr_rd_in = 1'b0;
      chk(sfr_rdata_out, exp);
   endtask

   // Unlock, check that the stall starts (or not), then wait it out under a bound
   task automatic fire(input logic exp_run);
      int n = 0;
      sfr_wr(OFF_CMD_PORT, UNLOCK_FIRST);
      sfr_wr(OFF_CMD_PORT, UNLOCK_SECOND);
      chk(cpu_stall_out, exp_run);
      while (cpu_stall_out === 1'b1 && n < 2000) begin
         @(negedge ref_clk_in);
         n++;
      end
      chk(cpu_stall_out, 1'b0);
   endtask

   // Software keeps reserved bits zero and the high address zero for hidden access
   task automatic setup(input logic [7:0] mode, input logic [15:0] addr);
      sfr_wr(OFF_MODE_SELECT, mode);
      sfr_wr(OFF_ADDR_HIGH, addr[15:8]);
      sfr_wr(OFF_ADDR_LOW, addr[7:0]);
   endtask

   initial begin
      repeat (4) @(negedge ref_clk_in);
      rst_n_in = 1'b1;
      sfr_rd(OFF_DATA_PORT, RST_DATA_PORT);
      sfr_rd(OFF_ADDR_HIGH, RST_ADDR);
      sfr_rd(OFF_MODE_SELECT, RST_MODE);
      sfr_rd(OFF_PROG_CONTROL, 8'h00);
      sfr_rd(OFF_CMD_PORT, 8'h00);
      sfr_rd(8'h10, 8'h00);
      setup(MODE_HID_READ, 16'h0003);
      fire(1'b0);
      sfr_wr(OFF_PROG_CONTROL, 8'h80);
      fire(1'b1);
      sfr_rd(OFF_DATA_PORT, RST_LOW_BOUND);
      // Even boundary 0x20 puts the data area at 0x2000..0x2FFF
      sfr_wr(OFF_DATA_PORT, 8'h20);
      setup(MODE_HID_WRITE, 16'h0003);
      fire(1'b1);
      setup(MODE_HID_READ, 16'h0003);
      fire(1'b1);
      sfr_rd(OFF_DATA_PORT, 8'h20);
      setup(MODE_HID_READ, 16'h0004);
      fire(1'b1);
      sfr_rd(OFF_DATA_PORT, 8'h00);
      // Reserved codes must never start anything, even with the enable bit set
      for (int k = 0; k < 2; k++) begin
         setup((k == 0) ? 8'h7F : 8'h83, 16'h2010);
         fire(1'b0);
      end
      setup(MODE_STANDBY, 16'h2010);
      fire(1'b0);
      setup(8'h06, 16'h2010);
      fire(1'b0);
      delay = 4'h3;
      setup(MODE_PROGRAM, 16'h2010);
      sfr_wr(OFF_DATA_PORT, 8'hA5);
      fire(1'b1);
      chk(fcu_flash_model_inst.mem[16'h2010], 8'hA5);
      sfr_rd(OFF_PROG_CONTROL, 8'h80);
      setup(MODE_READ, 16'h2010);
      fire(1'b1);
      sfr_rd(OFF_DATA_PORT, 8'hA5);
      setup(MODE_PROGRAM, 16'h1000);
      fire(1'b0);
      chk(fcu_flash_model_inst.mem[16'h1000], 8'hFF);
      boot_exec_in = 1'b1;
      fire(1'b1);
      chk(fcu_flash_model_inst.mem[16'h1000], 8'hA5);
      boot_exec_in = 1'b0;
      setup(MODE_ERASE, 16'h2155);
      fire(1'b1);
      chk(fcu_flash_model_inst.mem[16'h2010], 8'hFF);
      delay = 4'h0;
      setup(MODE_PROG_INC, 16'h2100);
      sfr_wr(OFF_DATA_PORT, 8'h11);
      fire(1'b1);
      sfr_wr(OFF_DATA_PORT, 8'h22);
      fire(1'b1);
      chk(fcu_flash_model_inst.mem[16'h2101], 8'h22);
      sfr_rd(OFF_ADDR_LOW, 8'h02);
      setup(MODE_READ_INC, 16'h2100);
      fire(1'b1);
      sfr_rd(OFF_DATA_PORT, 8'h11);
      sfr_rd(OFF_ADDR_LOW, 8'h01);
      sfr_wr(OFF_CMD_PORT, UNLOCK_FIRST);
      sfr_wr(OFF_CMD_PORT, 8'h00);
      sfr_wr(OFF_CMD_PORT, UNLOCK_SECOND);
      chk(cpu_stall_out, 1'b0);
      setup(MODE_PROGRAM, 16'h21FF);
      sfr_wr(OFF_DATA_PORT, 8'h5A);
      fire(1'b1);
      // CRC walk ends at 0x20*256 + 0x1FF, so two bytes from 0x21FE
      setup(MODE_CRC_READ, 16'h21FE);
      fire(1'b1);
      chk(crc_n[15:0], 16'h0002);
      chk(crc_last, 8'h5A);
      fail_mode = 1'b1;
      setup(MODE_READ, 16'h2010);
      fire(1'b1);
      sfr_rd(OFF_PROG_CONTROL, 8'h90);
      fail_mode = 1'b0;
      fire(1'b1);
      sfr_rd(OFF_PROG_CONTROL, 8'h80);
      sfr_wr(OFF_PROG_CONTROL, 8'hA0);
      chk(soft_reset_out, 1'b1);
      @(negedge ref_clk_in);
      chk(soft_reset_out, 1'b0);
      sfr_rd(OFF_PROG_CONTROL, 8'h80);
      sfr_wr(OFF_PROG_CONTROL, 8'hC0);
      chk(boot_source_out, 1'b1);
      sfr_wr(OFF_PROG_CONTROL, 8'h00);
      setup(MODE_READ, 16'h2010);
      fire(1'b0);
      chk(boot_source_out, 1'b0);
      complete_run();
   end

   initial begin
      #500000;
      n_errors++;
      complete_run();
   end
endmodule
